// ===== inc/mode_irq_consts.vh
// Constants for the reset mode selector and interrupt request front end.
`ifndef MODE_IRQ_CONSTS_VH
`define MODE_IRQ_CONSTS_VH
// ----------------------------------------------------------------------
// Mode encodings
// ----------------------------------------------------------------------
`define MODE_SINGLE_CHIP 2'h0
`define MODE_SELF_CHECK 2'h1
`define MODE_FACTORY_TEST 2'h2
// ----------------------------------------------------------------------
// Self-check phases
// ----------------------------------------------------------------------
`define CHK_IDLE 3'h0
`define CHK_PORTS 3'h1
`define CHK_RAM 3'h2
`define CHK_TIMER 3'h3
`define CHK_ROM 3'h4
`define CHK_DONE 3'h5
// ----------------------------------------------------------------------
// Timing and port reset directions
// ----------------------------------------------------------------------
`define SYS_CLK_HZ 10000000
`define MIN_REQUEST_PULSE_WIDTH_NS 250
`define MIN_REQUEST_PULSE_CYCLES ((`MIN_REQUEST_PULSE_WIDTH_NS * (`SYS_CLK_HZ / 1000000) + 999) / 1000)
`define PORT_RESET_DIR 8'h00
`define PORTC_RESET_DIR 4'h0
`define CHK_STEP_CYCLES 16'h0010
`endif

// ===== design/request_filter.v
// Synchroniser and minimum pulse width filter for the request pin.
`timescale 1ns/10ps
module request_filter #(
   parameter CNT_W = 8,
   parameter [CNT_W-1:0] MIN_CYCLES = 8'h03
) (
   // Clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // Pin and result
   input wire pin_n,
   output reg low_ok_ff,
   output reg level_low_ff
);
   reg [2:0] sync_ff;
   reg [CNT_W-1:0] cnt_ff;
   reg stable_ff;
   // Reset idles high, matching a released pin.
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_ff <= 3'h7;
         stable_ff <= 1'b1;
      end else begin
         sync_ff <= {sync_ff[1:0], pin_n};
         if (sync_ff[1] == sync_ff[2]) begin
            stable_ff <= sync_ff[2];
         end
      end
   end
   // A low shorter than the minimum width never reaches the latch.
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_ff <= {CNT_W{1'b0}};
         low_ok_ff <= 1'b0;
         level_low_ff <= 1'b0;
      end else begin
         level_low_ff <= ~stable_ff;
         if (stable_ff) begin
            cnt_ff <= {CNT_W{1'b0}};
            low_ok_ff <= 1'b0;
         end else if (cnt_ff + 1'b1 >= MIN_CYCLES) begin
            low_ok_ff <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff + 1'b1;
         end
      end
   end
endmodule // request_filter

// ===== design/reset_mode_irq.v
// Reset mode selection and external request front end.
//
// Summary of operation
// - Build option picks falling-edge only or falling-edge plus low-level sensing.
// - A low held at least the minimum width sets the pending latch while the test level is low.
// - Latch is tested at instruction end; service only when mask is clear.
// - A masked request stays pending and is served once mask clears.
// - Without the PLL the bus clock is the oscillator divided by two.
// - Reset low forces a defined start-up state on the core, request latch, port directions and self-check.
// - All port lines of both byte ports and nibble port become inputs.
// - Exactly three modes, chosen from pin conditions at reset end.
// - Normal request level at reset release gives single-chip mode.
// - Test level with strap high gives self-check, strap low factory test.
// - Single-chip mode keeps buses internal and offers general ports.
// - Self-check enables the PLL before the automatic checks begin.
// - Checks run ports, RAM, timer flags, then ROM parity in order.
`timescale 1ns/10ps
`include "mode_irq_consts.vh"
module reset_mode_irq #(
   parameter LEVEL_SENSE = 1'b0
) (
   // Clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // Board pins
   input wire reset_pin_n,
   input wire request_pin_n,
   input wire test_select_level,
   input wire mode_strap_pin,
   // Core handshake
   input wire instr_done,
   input wire irq_mask,
   input wire timer_overflow_flag,
   input wire realtime_interrupt_flag,
   input wire chk_step_ok,
   // Results
   output reg [1:0] mode_ff,
   output reg core_reset_ff,
   output reg irq_pending_ff,
   output reg irq_start_ff,
   output reg bus_clk_en_ff,
   output reg pll_enable_ff,
   output reg external_bus_en_ff,
   output reg [7:0] porta_dir_ff,
   output reg [7:0] portb_dir_ff,
   output reg [3:0] portc_dir_ff,
   output reg [2:0] chk_phase_ff,
   output reg chk_fail_ff
);
   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   reg [2:0] rst_sync_ff;
   reg [2:0] tst_sync_ff;
   reg [2:0] strap_sync_ff;
   reg rst_low_ff;
   reg tst_ff;
   reg strap_ff;
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_sync_ff <= 3'h0;
         tst_sync_ff <= 3'h0;
         strap_sync_ff <= 3'h0;
         rst_low_ff <= 1'b1;
         tst_ff <= 1'b0;
         strap_ff <= 1'b0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[1:0], reset_pin_n};
         tst_sync_ff <= {tst_sync_ff[1:0], test_select_level};
         strap_sync_ff <= {strap_sync_ff[1:0], mode_strap_pin};
         if (rst_sync_ff[1] == rst_sync_ff[2]) begin
            rst_low_ff <= ~rst_sync_ff[2];
         end
         if (tst_sync_ff[1] == tst_sync_ff[2]) begin
            tst_ff <= tst_sync_ff[2];
         end
         if (strap_sync_ff[1] == strap_sync_ff[2]) begin
            strap_ff <= strap_sync_ff[2];
         end
      end
   end
   // ----------------------------------------------------------------------
   // Request filter
   // ----------------------------------------------------------------------
   wire low_ok;
   // The count is reckoned as an integer, then cut to the filter's counter width.
   localparam integer MIN_PULSE_INT = `MIN_REQUEST_PULSE_CYCLES;
   localparam [7:0] MIN_PULSE = MIN_PULSE_INT[7:0];
   request_filter #(
      .CNT_W(8),
      .MIN_CYCLES(MIN_PULSE)
   ) u_filter (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pin_n(request_pin_n),
      .low_ok_ff(low_ok),
      .level_low_ff()
   );
   reg low_ok_d_ff;
   wire fall_evt = low_ok & ~low_ok_d_ff;
   wire req_evt = fall_evt | (LEVEL_SENSE & low_ok);
   wire service = instr_done & irq_pending_ff & ~irq_mask & ~core_reset_ff;
   // ----------------------------------------------------------------------
   // Mode capture, reset hold and request latch
   // ----------------------------------------------------------------------
   // The external reset pin and the system reset both hold the core, so
   // mode capture happens at the first cycle the pin is seen high.
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_ff <= `MODE_SINGLE_CHIP;
         core_reset_ff <= 1'b1;
         low_ok_d_ff <= 1'b0;
         irq_pending_ff <= 1'b0;
         irq_start_ff <= 1'b0;
         porta_dir_ff <= `PORT_RESET_DIR;
         portb_dir_ff <= `PORT_RESET_DIR;
         portc_dir_ff <= `PORTC_RESET_DIR;
         external_bus_en_ff <= 1'b0;
      end else begin
         low_ok_d_ff <= low_ok;
         irq_start_ff <= service;
         external_bus_en_ff <= 1'b0;
         if (rst_low_ff) begin
            core_reset_ff <= 1'b1;
            irq_pending_ff <= 1'b0;
            porta_dir_ff <= `PORT_RESET_DIR;
            portb_dir_ff <= `PORT_RESET_DIR;
            portc_dir_ff <= `PORTC_RESET_DIR;
         end else begin
            if (core_reset_ff) begin
               core_reset_ff <= 1'b0;
               if (!tst_ff) begin
                  mode_ff <= `MODE_SINGLE_CHIP;
               end else if (strap_ff) begin
                  mode_ff <= `MODE_SELF_CHECK;
               end else begin
                  mode_ff <= `MODE_FACTORY_TEST;
               end
            end
            // A new request in the service cycle wins over the clear.
            if (req_evt && !tst_ff) begin
               irq_pending_ff <= 1'b1;
            end else if (service) begin
               irq_pending_ff <= 1'b0;
            end
         end
      end
   end
   // ----------------------------------------------------------------------
   // Bus clock divider
   // ----------------------------------------------------------------------
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_clk_en_ff <= 1'b0;
      end else begin
         bus_clk_en_ff <= ~bus_clk_en_ff;
      end
   end
   // ----------------------------------------------------------------------
   // Self-check sequencer
   // ----------------------------------------------------------------------
   // Each phase waits a fixed settle time, then takes the core's verdict.
   reg [15:0] step_cnt_ff;
   reg [15:0] nxt_step_cnt;
   reg [2:0] nxt_phase;
   reg nxt_fail;
   wire step_end = (step_cnt_ff == `CHK_STEP_CYCLES);
   always @* begin
      nxt_phase = chk_phase_ff;
      nxt_fail = chk_fail_ff;
      nxt_step_cnt = step_end ? 16'h0000 : step_cnt_ff + 16'h0001;
      case (chk_phase_ff)
         `CHK_IDLE: begin
            nxt_step_cnt = 16'h0000;
            if (mode_ff == `MODE_SELF_CHECK && !core_reset_ff && pll_enable_ff) begin
               nxt_phase = `CHK_PORTS;
            end
         end
         `CHK_PORTS, `CHK_RAM, `CHK_ROM: begin
            if (step_end) begin
               nxt_fail = chk_fail_ff | ~chk_step_ok;
               nxt_phase = chk_phase_ff + 3'h1;
            end
         end
         `CHK_TIMER: begin
            if (step_end) begin
               nxt_fail = chk_fail_ff | ~(chk_step_ok & timer_overflow_flag
                  & realtime_interrupt_flag);
               nxt_phase = `CHK_ROM;
            end
         end
         `CHK_DONE: begin
            nxt_step_cnt = 16'h0000;
         end
         default: begin
            nxt_phase = `CHK_IDLE;
            nxt_step_cnt = 16'h0000;
         end
      endcase
   end
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         chk_phase_ff <= `CHK_IDLE;
         chk_fail_ff <= 1'b0;
         step_cnt_ff <= 16'h0000;
         pll_enable_ff <= 1'b0;
      end else if (core_reset_ff) begin
         chk_phase_ff <= `CHK_IDLE;
         chk_fail_ff <= 1'b0;
         step_cnt_ff <= 16'h0000;
         pll_enable_ff <= 1'b0;
      end else begin
         chk_phase_ff <= nxt_phase;
         chk_fail_ff <= nxt_fail;
         step_cnt_ff <= nxt_step_cnt;
         pll_enable_ff <= (mode_ff == `MODE_SELF_CHECK);
      end
   end
endmodule // reset_mode_irq

// ===== verification/mode_irq_properties.sv
// Checker for the reset mode selector and request front end.
`timescale 1ns/10ps
module mode_irq_properties (
   // Clock and reset
   input logic sys_clk,
   input logic sys_rst,
   // Pins and core side
   input logic reset_pin_n,
   input logic test_select_level,
   input logic mode_strap_pin,
   input logic instr_done,
   input logic irq_mask,
   // Results
   input logic [1:0] mode_ff,
   input logic core_reset_ff,
   input logic irq_pending_ff,
   input logic irq_start_ff,
   input logic bus_clk_en_ff,
   input logic pll_enable_ff,
   input logic external_bus_en_ff,
   input logic [7:0] porta_dir_ff,
   input logic [7:0] portb_dir_ff,
   input logic [3:0] portc_dir_ff,
   input logic [2:0] chk_phase_ff
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_no_early_start:
   assert property (!(irq_pending_ff && instr_done && !irq_mask) |=> !irq_start_ff)
      else $error("service began without an unmasked pending request");
   a_service_begins:
   assert property (irq_pending_ff && instr_done && !irq_mask && !core_reset_ff |=> irq_start_ff)
      else $error("pending request was not serviced");
   a_masked_kept:
   assert property (irq_pending_ff && irq_mask && reset_pin_n && !core_reset_ff |=> irq_pending_ff)
      else $error("masked request was lost");
   a_single_service:
   assert property (irq_start_ff |=> !irq_start_ff) else $error("service pulse too long");
   a_bus_clk_half:
   assert property (1'b1 |=> bus_clk_en_ff != $past(bus_clk_en_ff))
      else $error("bus clock enable did not toggle");
   a_ports_input:
   assert property (core_reset_ff |-> porta_dir_ff == 8'h00 && portb_dir_ff == 8'h00
      && portc_dir_ff == 4'h0) else $error("port line left as output in reset");
   a_bus_internal:
   assert property (external_bus_en_ff == 1'b0) else $error("external bus enabled");
   a_mode_choice:
   assert property ($fell(core_reset_ff) |-> mode_ff == (test_select_level ?
      (mode_strap_pin ? 2'h1 : 2'h2) : 2'h0)) else $error("wrong mode at release");
   a_pll_first:
   assert property (chk_phase_ff != 3'h0 |-> pll_enable_ff && mode_ff == 2'h1)
      else $error("checks running without pll");
   a_phase_order:
   assert property ($changed(chk_phase_ff) && $past(chk_phase_ff) != 3'h0 && !core_reset_ff
      && reset_pin_n |-> chk_phase_ff == $past(chk_phase_ff) + 3'h1)
      else $error("check phase out of order");
   c_served: cover property (irq_start_ff);
   c_checks_done: cover property (chk_phase_ff == 3'h5);
   c_factory: cover property (mode_ff == 2'h2 && !core_reset_ff);
endmodule // mode_irq_properties
bind reset_mode_irq mode_irq_properties chk (.sys_clk, .sys_rst, .reset_pin_n,
   .test_select_level, .mode_strap_pin, .instr_done, .irq_mask, .mode_ff, .core_reset_ff,
   .irq_pending_ff, .irq_start_ff, .bus_clk_en_ff, .pll_enable_ff, .external_bus_en_ff,
   .porta_dir_ff, .portb_dir_ff, .portc_dir_ff, .chk_phase_ff);

// ===== verification/board_pins.sv
// Board-level driver of the reset, request and strap pins.
`timescale 1ns/10ps
module board_pins (
   // Clock
   input logic sys_clk,
   // Pins
   output logic reset_pin_n,
   output logic request_pin_n,
   output logic test_select_level,
   output logic mode_strap_pin
);
   // Reset starts low, as it does at power-on.
   initial begin
      reset_pin_n = 1'b0;
      request_pin_n = 1'b1;
      test_select_level = 1'b0;
      mode_strap_pin = 1'b0;
   end
   // Straps stay put past release so the mode sampling sees stable levels.
   task automatic hold_reset(input int len, input logic tst, input logic strap);
      @(posedge sys_clk);
      reset_pin_n <= 1'b0;
      test_select_level <= tst;
      mode_strap_pin <= strap;
      repeat (len) @(posedge sys_clk);
      reset_pin_n <= 1'b1;
   endtask
   task automatic request(input int len);
      @(posedge sys_clk);
      request_pin_n <= 1'b0;
      repeat (len) @(posedge sys_clk);
      request_pin_n <= 1'b1;
   endtask
endmodule // board_pins

// ===== verification/reset_mode_irq_tb.sv
// Self-checking bench for reset mode selection and request handling.
`timescale 1ns/10ps
module reset_mode_irq_tb;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic instr_done = 1'b0;
   logic irq_mask = 1'b0;
   logic timer_overflow_flag = 1'b1;
   logic realtime_interrupt_flag = 1'b1;
   logic chk_step_ok = 1'b1;
   wire reset_pin_n, request_pin_n, test_select_level, mode_strap_pin;
   wire core_reset_ff, irq_pending_ff, irq_start_ff, bus_clk_en_ff, pll_enable_ff;
   wire external_bus_en_ff, chk_fail_ff;
   wire [1:0] mode_ff;
   wire [7:0] porta_dir_ff, portb_dir_ff;
   wire [3:0] portc_dir_ff;
   wire [2:0] chk_phase_ff;
   wire lvl_pending, lvl_start;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   // Rows hold test level, strap and expected mode; the last row enters self-check.
   logic [3:0] rows [3] = '{4'h0, 4'ha, 4'hd};
   reset_mode_irq dut (.sys_clk, .sys_rst, .reset_pin_n, .request_pin_n, .test_select_level,
      .mode_strap_pin, .instr_done, .irq_mask, .timer_overflow_flag, .realtime_interrupt_flag,
      .chk_step_ok, .mode_ff, .core_reset_ff, .irq_pending_ff, .irq_start_ff, .bus_clk_en_ff,
      .pll_enable_ff, .external_bus_en_ff, .porta_dir_ff, .portb_dir_ff, .portc_dir_ff,
      .chk_phase_ff, .chk_fail_ff);
   // A second copy built with level sensing shares every pin with the first.
   reset_mode_irq #(.LEVEL_SENSE(1'b1)) dut_lvl (.sys_clk, .sys_rst, .reset_pin_n,
      .request_pin_n, .test_select_level, .mode_strap_pin, .instr_done, .irq_mask,
      .timer_overflow_flag, .realtime_interrupt_flag, .chk_step_ok, .mode_ff(),
      .core_reset_ff(), .irq_pending_ff(lvl_pending), .irq_start_ff(lvl_start),
      .bus_clk_en_ff(), .pll_enable_ff(), .external_bus_en_ff(), .porta_dir_ff(),
      .portb_dir_ff(), .portc_dir_ff(), .chk_phase_ff(), .chk_fail_ff());
   board_pins board (.sys_clk, .reset_pin_n, .request_pin_n, .test_select_level,
      .mode_strap_pin);
   initial forever #50 sys_clk = ~sys_clk;
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task pulse_done;
      @(posedge sys_clk) instr_done <= 1'b1;
      @(posedge sys_clk) instr_done <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic wait_release;
      int n;
      n = 0;
      while (core_reset_ff !== 1'b0 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      check("release", 8'h00, {7'h00, core_reset_ff});
   endtask
   // The ceiling is generous: power-on reset alone takes 4064 cycles.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         failures++;
         conclude;
      end
   end
   initial begin
      int n;
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         board.hold_reset(i == 0 ? 4064 : 8, rows[i][3], rows[i][2]);
         wait_release;
         check("mode", {6'h00, rows[i][1:0]}, {6'h00, mode_ff});
         check("dirs", 8'h00, porta_dir_ff | portb_dir_ff | {4'h0, portc_dir_ff});
         check("ext bus", 8'h00, {7'h00, external_bus_en_ff});
      end
      repeat (2) @(negedge sys_clk);
      check("pll", 8'h01, {7'h00, pll_enable_ff});
      n = 0;
      while (chk_phase_ff !== 3'h5 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      check("phase", 8'h05, {5'h00, chk_phase_ff});
      check("chk fail", 8'h00, {7'h00, chk_fail_ff});
      // A missing timer flag must be caught by the timer phase.
      @(posedge sys_clk) timer_overflow_flag <= 1'b0;
      board.hold_reset(8, 1'b1, 1'b1);
      wait_release;
      n = 0;
      while (chk_phase_ff !== 3'h5 && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      check("timer flag fail", 8'h01, {7'h00, chk_fail_ff});
      board.hold_reset(8, 1'b0, 1'b1);
      wait_release;
      // Two cycles low passes the synchroniser but is shorter than the minimum width.
      board.request(2);
      repeat (12) @(negedge sys_clk);
      check("glitch", 8'h00, {7'h00, irq_pending_ff});
      @(posedge sys_clk) irq_mask <= 1'b1;
      board.request(6);
      repeat (12) @(negedge sys_clk);
      check("pending", 8'h01, {7'h00, irq_pending_ff});
      pulse_done;
      check("masked start", 8'h00, {7'h00, irq_start_ff});
      check("kept", 8'h01, {7'h00, irq_pending_ff});
      @(posedge sys_clk) irq_mask <= 1'b0;
      pulse_done;
      check("start", 8'h01, {7'h00, irq_start_ff});
      check("cleared", 8'h00, {7'h00, irq_pending_ff});
      pulse_done;
      check("second start", 8'h00, {7'h00, irq_start_ff});
      // A low held through the service re-arms only the level-sensing copy.
      fork
         board.request(16);
         begin
            repeat (10) @(negedge sys_clk);
            pulse_done;
            check("level start", 8'h01, {7'h00, lvl_start});
            repeat (2) @(negedge sys_clk);
            check("level rearm", 8'h01, {7'h00, lvl_pending});
            check("edge once", 8'h00, {7'h00, irq_pending_ff});
         end
      join
      conclude;
   end
endmodule // reset_mode_irq_tb
